// ==== rtl/bpe_top.sv ====
// Top: bidirectional lines, debounce, edge events, encoder and routing
// Function
// - Software picks input or output direction for each bidirectional line on its own.
// - After reset both bidirectional lines are inputs until software selects output.
// - Each bidirectional line behaves like a dedicated input or output line in either direction.
// - Input lines and internal signals are routed to processing, and a choice goes to the trigger.
// - The encoder emits a one-cycle tick per transition and keeps a resettable position count.
// - Phase and quadrature each select any of three lines, taken after that line's debounce.
// - Each line has its own debounce time of 0 to 65535 us in 1 us steps, 0 bypassing it.
// - Each line latches rise and fall flags, cleared by reading, extra same edges being lost.
// - The position is readable at any time as an unsigned 32-bit latest count.
// - All lines stay disabled from reset until enumeration completes, then enable themselves.
`default_nettype none
module bpe_top (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic enum_done_i,
    input wire logic [bpe_pkg::N_BIDIR-1:0] bidir_line_i,
    output logic [bpe_pkg::N_BIDIR-1:0] bidir_line_o,
    output logic [bpe_pkg::N_BIDIR-1:0] bidir_line_oe_o,
    input wire logic opto_in_i,
    input wire logic [bpe_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [bpe_pkg::N_LINES-1:0] line_filt_o,
    output logic enc_tick_o,
    output logic trig_o
);
    import bpe_pkg::*;

    localparam logic [6:0] US_LAST = 7'(US_CYC - 1);

    bpe_ctrl_s ctrl_r;
    bpe_enc_s enc_cfg_r;
    logic [DEB_W-1:0] deb_r [N_LINES];
    logic [N_LINES-1:0] raw;
    logic [N_LINES-1:0] s1_r;
    logic [N_LINES-1:0] s2_r;
    logic [N_LINES-1:0] line_in;
    logic [N_LINES-1:0] filt_r;
    logic [N_LINES-1:0] filt_d_r;
    logic [N_LINES-1:0] rise_r;
    logic [N_LINES-1:0] fall_r;
    logic [N_LINES-1:0] rise_ev;
    logic [N_LINES-1:0] fall_ev;
    logic [1:0] en_s_r;
    logic [6:0] us_cnt_r;
    logic us_tick;
    logic [1:0] ab;
    logic [1:0] ab_d_r;
    logic fwd;
    logic bwd;
    logic [POS_W-1:0] pos_r;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_pos;
    logic rd_evt;

    ////////////////////////////////////////////////////////////////////
    // Enable sync and microsecond divider
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            en_s_r <= 2'h0;
        end else begin
            en_s_r <= {en_s_r[0], enum_done_i};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            us_cnt_r <= 7'h00;
        end else if (us_tick) begin
            us_cnt_r <= 7'h00;
        end else begin
            us_cnt_r <= us_cnt_r + 7'h01;
        end
    end
    assign us_tick = (us_cnt_r == US_LAST);

    ////////////////////////////////////////////////////////////////////
    // Register writes
    assign wr_ctrl = wr_i && (addr_i == OFF_CTRL);
    assign wr_cfg = wr_i && (addr_i == OFF_ENC_CFG);
    assign wr_pos = wr_i && (addr_i == OFF_ENC_POS);
    assign rd_evt = rd_i && (addr_i == OFF_EVT);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= wdata_i[$bits(bpe_ctrl_s)-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            enc_cfg_r <= ENC_RST;
        end else if (wr_cfg) begin
            enc_cfg_r <= wdata_i[$bits(bpe_enc_s)-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drive
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            bidir_line_oe_o <= 2'h0;
            bidir_line_o <= 2'h0;
        end else begin
            bidir_line_oe_o <= ctrl_r.dir & {N_BIDIR{en_s_r[1]}};
            bidir_line_o <= ctrl_r.val & {N_BIDIR{en_s_r[1]}};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-line sync, debounce and events
    assign raw = {opto_in_i, bidir_line_i};
    assign line_in = s2_r & {N_LINES{en_s_r[1]}};

    genvar g;
    generate
        for (g = 0; g < N_LINES; g++) begin : g_line
            logic [DEB_W-1:0] cnt_r;

            always_ff @(posedge sys_clk_i) begin
                if (!rstn_i) begin
                    deb_r[g] <= 16'h0000;
                end else if (wr_i && (addr_i == OFF_DEB0 + 8'(4 * g))) begin
                    deb_r[g] <= wdata_i[DEB_W-1:0];
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (!rstn_i) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= raw[g];
                    s2_r[g] <= s1_r[g];
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (!rstn_i) begin
                    filt_r[g] <= 1'b0;
                    cnt_r <= 16'h0000;
                end else if (deb_r[g] == 16'h0000) begin
                    filt_r[g] <= line_in[g];
                    cnt_r <= 16'h0000;
                end else if (line_in[g] == filt_r[g]) begin
                    cnt_r <= 16'h0000;
                end else if (us_tick) begin
                    if (cnt_r + 16'h0001 >= deb_r[g]) begin
                        filt_r[g] <= line_in[g];
                        cnt_r <= 16'h0000;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
            end

            assign rise_ev[g] = filt_r[g] && !filt_d_r[g];
            assign fall_ev[g] = !filt_r[g] && filt_d_r[g];

            always_ff @(posedge sys_clk_i) begin
                if (!rstn_i) begin
                    rise_r[g] <= 1'b0;
                    fall_r[g] <= 1'b0;
                end else begin
                    rise_r[g] <= rise_ev[g] || (rise_r[g] && !rd_evt);
                    fall_r[g] <= fall_ev[g] || (fall_r[g] && !rd_evt);
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            filt_d_r <= 3'h0;
            line_filt_o <= 3'h0;
        end else begin
            filt_d_r <= filt_r;
            line_filt_o <= filt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Quadrature encoder
    assign ab = {filt_r[enc_cfg_r.sel_b], filt_r[enc_cfg_r.sel_a]};
    assign fwd = (ab_d_r == 2'h0 && ab == 2'h1) || (ab_d_r == 2'h1 && ab == 2'h3) ||
                 (ab_d_r == 2'h3 && ab == 2'h2) || (ab_d_r == 2'h2 && ab == 2'h0);
    assign bwd = (ab_d_r == 2'h1 && ab == 2'h0) || (ab_d_r == 2'h3 && ab == 2'h1) ||
                 (ab_d_r == 2'h2 && ab == 2'h3) || (ab_d_r == 2'h0 && ab == 2'h2);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ab_d_r <= 2'h0;
        end else begin
            ab_d_r <= ab;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pos_r <= ZERO_W;
        end else if (wr_pos) begin
            pos_r <= ZERO_W;
        end else if (fwd) begin
            pos_r <= pos_r + 32'h0000_0001;
        end else if (bwd) begin
            pos_r <= pos_r - 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            enc_tick_o <= 1'b0;
            trig_o <= 1'b0;
        end else begin
            enc_tick_o <= fwd || bwd;
            if (enc_cfg_r.trig_sel == TRIG_TICK) begin
                trig_o <= fwd || bwd;
            end else begin
                trig_o <= filt_r[enc_cfg_r.trig_sel];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= ZERO_W;
        end else if (rd_i) begin
            unique case (addr_i)
                OFF_CTRL: rdata_o <= 32'(ctrl_r);
                OFF_DEB0: rdata_o <= 32'(deb_r[0]);
                OFF_DEB1: rdata_o <= 32'(deb_r[1]);
                OFF_DEB2: rdata_o <= 32'(deb_r[2]);
                OFF_STAT: rdata_o <= 32'({en_s_r[1], filt_r});
                OFF_EVT: rdata_o <= 32'({1'b0, fall_r, 1'b0, rise_r});
                OFF_ENC_CFG: rdata_o <= 32'(enc_cfg_r);
                OFF_ENC_POS: rdata_o <= pos_r;
                default: rdata_o <= ZERO_W;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_rst;
        !rstn_i;
    endsequence

    sequence s_step;
        fwd && !wr_pos;
    endsequence

    property p_rst_input;
        @(posedge sys_clk_i) s_rst |=> bidir_line_oe_o == 2'h0;
    endproperty
    a_rst_input: assert property (p_rst_input) else $error("line driven after reset");

    property p_no_drive_input;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            bidir_line_oe_o != 2'h0 |-> (bidir_line_oe_o & ~$past(ctrl_r.dir)) == 2'h0;
    endproperty
    a_no_drive_input: assert property (p_no_drive_input) else $error("input line driven");

    property p_disabled;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            !en_s_r[1] |=> bidir_line_oe_o == 2'h0 && bidir_line_o == 2'h0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("line active before enable");

    property p_dir_write;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            wr_ctrl |=> ctrl_r.dir == $past(wdata_i[1:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not stored");

    property p_pos_inc;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_step |=> pos_r == $past(pos_r) + 32'h0000_0001 ##0 enc_tick_o;
    endproperty
    a_pos_inc: assert property (p_pos_inc) else $error("position not advanced");

    property p_tick_cause;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            enc_tick_o |-> $past(ab) != $past(ab_d_r);
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("tick without transition");

    property p_bypass;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            deb_r[0] == 16'h0000 ##1 deb_r[0] == 16'h0000 |-> filt_r[0] == $past(line_in[0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not transparent");

    property p_evt_clear;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            rd_evt |=> (rise_r & ~$past(rise_ev)) == 3'h0 && (fall_r & ~$past(fall_ev)) == 3'h0;
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event not cleared");

    property p_pos_read;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            rd_i && addr_i == OFF_ENC_POS |=> rdata_o == $past(pos_r);
    endproperty
    a_pos_read: assert property (p_pos_read) else $error("position read wrong");

endmodule : bpe_top
`default_nettype wire

// ==== rtl/bpe_pkg.sv ====
// Package: constants and types for the port and encoder routing block
`default_nettype none
package bpe_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEB_STEP_NS = 1000;
    localparam int US_CYC = DEB_STEP_NS / CLK_PERIOD_NS;
    localparam int DEB_W = 16;
    localparam int N_LINES = 3;
    localparam int N_BIDIR = 2;
    localparam int ADDR_W = 8;
    localparam int POS_W = 32;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DEB0 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DEB1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DEB2 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_ENC_CFG = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_ENC_POS = 8'h1C;
    localparam int EVT_FALL_LSB = 4;
    localparam int STAT_EN_BIT = 3;
    localparam logic [31:0] ZERO_W = 32'h0000_0000;
    typedef struct packed {
        logic [1:0] val;
        logic [1:0] dir;
    } bpe_ctrl_s;
    typedef struct packed {
        logic [1:0] trig_sel;
        logic [1:0] sel_b;
        logic [1:0] sel_a;
    } bpe_enc_s;
    localparam bpe_ctrl_s CTRL_RST = 4'h0;
    localparam bpe_enc_s ENC_RST = 6'h04;
    localparam logic [1:0] TRIG_TICK = 2'h3;
endpackage : bpe_pkg
`default_nettype wire

// ==== sim/bpe_enc_model.sv ====
// Partner: quadrature encoder on the two bidirectional pads
`default_nettype none
module bpe_enc_model (
    input wire logic sys_clk_i,
    input wire logic step_i,
    input wire logic fwd_i,
    output logic a_o,
    output logic b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] idx_r = 2'h0;
    // One gray step per request, phase leading when forward
    always @(posedge sys_clk_i) begin
        if (step_i) begin
            idx_r <= fwd_i ? idx_r + 2'h1 : idx_r - 2'h1;
        end
    end
    assign a_o = idx_r[1] ^ idx_r[0];
    assign b_o = idx_r[1];
endmodule : bpe_enc_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Testbench: pads, debounce, events, routing and encoder position
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bpe_pkg::*;
    logic clk = 1'b0;
    logic rstn_i, enum_done_i, opto_in_i, wr_i, rd_i, step, fwd, enc_a, enc_b;
    logic [ADDR_W-1:0] addr_i;
    logic [31:0] wdata_i, rdata_o, d, exp_pos;
    logic [N_BIDIR-1:0] pad, out, oe;
    logic [N_LINES-1:0] filt;
    logic tick, trig;
    int n_fail = 0, num_checks = 0, n_tick = 0, n_trig = 0, g;
    always #5 clk = ~clk;
    assign pad = {oe[1] ? out[1] : enc_b, oe[0] ? out[0] : enc_a};
    bpe_top dut_u (.sys_clk_i(clk), .rstn_i(rstn_i), .enum_done_i(enum_done_i),
        .bidir_line_i(pad), .bidir_line_o(out), .bidir_line_oe_o(oe), .opto_in_i(opto_in_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .line_filt_o(filt), .enc_tick_o(tick), .trig_o(trig));
    bpe_enc_model enc_u (.sys_clk_i(clk), .step_i(step), .fwd_i(fwd), .a_o(enc_a), .b_o(enc_b));
    always @(posedge clk) begin
        if (tick === 1'b1) n_tick++;
        if (trig === 1'b1) n_trig++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        @(posedge clk);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    function automatic logic [31:0] pos_next(input logic [31:0] p, input logic f);
        return f ? p + 32'h1 : p - 32'h1;
    endfunction : pos_next
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        rstn_i = 1'b0; enum_done_i = 1'b0; opto_in_i = 1'b1; addr_i = '0; wdata_i = '0;
        wr_i = 1'b0; rd_i = 1'b0; step = 1'b0; fwd = 1'b0;
        void'($urandom(32'h7ffd));
        wait_cyc(20);
        chk("oe_in_reset", 32'h0, oe);
        @(posedge clk);
        rstn_i <= 1'b1;
        wr(OFF_DEB0, 32'h0);
        wr(OFF_DEB1, 32'h0);
        wr(OFF_DEB2, 32'h0);
        wait_cyc(8);
        chk("filt_disabled", 32'h0, filt);
        rd(OFF_STAT, d);
        chk("stat_disabled", 32'h0, d);
        rd(8'hFC, d);
        chk("unmapped", 32'h0, d);
        wr(OFF_CTRL, 32'h0000_000F);
        wait_cyc(2);
        chk("oe_disabled", 32'h0, oe);
        chk("out_disabled", 32'h0, out);
        wr(OFF_CTRL, 32'h0);
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(OFF_CTRL, d);
        chk("unmapped_wr", 32'h0, d);
        @(posedge clk);
        enum_done_i <= 1'b1;
        wait_cyc(12);
        rd(OFF_STAT, d);
        chk("stat_enabled", 32'h0000_000C, d);
        chk("oe_after_enable", 32'h0, oe);
        $display("test enable done");
        wr(OFF_CTRL, 32'h0000_0005);
        wait_cyc(1);
        chk("oe_line0", 32'h1, oe);
        chk("out_line0", 32'h1, out);
        rd(OFF_CTRL, d);
        chk("ctrl_read", 32'h0000_0005, d);
        wr(OFF_CTRL, 32'h0000_000A);
        wait_cyc(1);
        chk("oe_line1", 32'h2, oe);
        chk("out_line1", 32'h2, out);
        wr(OFF_CTRL, 32'h0);
        wait_cyc(1);
        chk("oe_inputs", 32'h0, oe);
        $display("test direction done");
        wait_cyc(8);
        rd(OFF_EVT, d);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            opto_in_i <= ~opto_in_i;
            wait_cyc(8);
        end
        rd(OFF_EVT, d);
        chk("evt_overrun", 32'h0000_0044, d);
        rd(OFF_EVT, d);
        chk("evt_cleared", 32'h0, d);
        $display("test events done");
        wr(OFF_DEB2, 32'h2);
        rd(OFF_DEB2, d);
        chk("deb_readback", 32'h2, d);
        g = 10 + int'($urandom % 30);
        @(posedge clk);
        opto_in_i <= 1'b0;
        repeat (g) @(posedge clk);
        opto_in_i <= 1'b1;
        wait_cyc(300);
        chk("glitch_filtered", 32'h1, filt[2]);
        @(posedge clk);
        opto_in_i <= 1'b0;
        wait_cyc(90);
        chk("deb_not_early", 32'h1, filt[2]);
        for (int i = 0; i < 400 && filt[2] !== 1'b0; i++) wait_cyc(1);
        chk("deb_settled", 32'h0, filt[2]);
        rd(OFF_EVT, d);
        chk("deb_events", 32'h0000_0040, d);
        $display("test debounce done");
        wr(OFF_ENC_CFG, 32'h0000_0024);
        wr(OFF_DEB2, 32'h0);
        rd(OFF_ENC_CFG, d);
        chk("cfg_readback", 32'h0000_0024, d);
        @(posedge clk);
        opto_in_i <= 1'b1;
        wait_cyc(8);
        chk("trig_line2_hi", 32'h1, trig);
        @(posedge clk);
        opto_in_i <= 1'b0;
        wait_cyc(8);
        chk("trig_line2_lo", 32'h0, trig);
        $display("test routing done");
        wr(OFF_ENC_CFG, 32'h0000_0034);
        wr(OFF_ENC_POS, 32'hFFFF_FFFF);
        rd(OFF_ENC_POS, d);
        chk("pos_reset", 32'h0, d);
        n_tick = 0;
        n_trig = 0;
        exp_pos = 32'h0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            fwd <= (i == 0) ? 1'b0 : 1'($urandom);
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            wait_cyc(8);
            exp_pos = pos_next(exp_pos, fwd);
            if (i == 0) begin
                rd(OFF_ENC_POS, d);
                chk("pos_wrap", exp_pos, d);
            end
        end
        rd(OFF_ENC_POS, d);
        chk("pos_final", exp_pos, d);
        chk("tick_count", 32'd40, n_tick);
        chk("trig_tick_count", 32'd40, n_trig);
        $display("test encoder done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
